// ===== hw/usda_pkg.sv
package usda_pkg;
    // aliases: sixteen words starting at alias 0, byte addresses inside the peripheral window
    localparam logic [31:0] ALIAS_BASE = 32'h50001130;
    localparam logic [31:0] ALIAS_6 = 32'h50001148;
    localparam logic [31:0] ALIAS_7 = 32'h5000114c;
    localparam logic [31:0] ALIAS_8 = 32'h50001150;
    localparam int ALIAS_COUNT = 16;
    localparam int ALIAS_SPAN = 64;
    // own control/status registers
    localparam logic [31:0] CTRL_ADDR = 32'h50001170;
    localparam logic [31:0] STAT_ADDR = 32'h50001174;
    localparam logic [31:0] IRQ_STAT_ADDR = 32'h50001178;
    localparam logic [31:0] IRQ_CLR_ADDR = 32'h5000117c;
    localparam logic [31:0] IRQ_EN_ADDR = 32'h50001180;
    localparam int CTRL_FIFO_EN = 0;
    localparam int CTRL_IR_MODE = 1;
    localparam int STAT_DATA_READY = 0;
    localparam int STAT_OVERRUN = 1;
    localparam int STAT_HOLDING_EMPTY = 5;
    localparam int EV_OVERRUN = 0;
    localparam int EV_RX_READY = 1;
    localparam int EV_TX_EMPTY = 2;
    localparam int EV_WIDTH = 3;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } usda_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } usda_apb_rsp_s;
endpackage

// ===== hw/usda_shadow_alias.sv
`timescale 1ns/10ps
// Operation
// - sixteen word aliases share one data path
// - reads return received byte in bits 7:0
// - read data valid only with data ready
// - no fifo: new byte overwrites, flags overrun
// - fifo mode: read pops oldest entry
// - full receive fifo drops new byte, overrun
// - write queues low byte for transmit
// - no fifo: one write clears holding empty
// - no fifo: further writes replace pending byte
// - fifo mode accepts writes up to depth
// - writes to full transmit fifo discarded
module usda_shadow_alias #(
    parameter int DEPTH = usda_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire usda_pkg::usda_apb_req_s apbReq,
    output usda_pkg::usda_apb_rsp_s apbRsp,
    // receiver side: one-cycle strobe with the assembled character
    input wire logic rxStrobe,
    input wire logic [7:0] rxByte,
    // transmitter side: pops a byte when it is ready to shift one out
    input wire logic txTake,
    output logic [7:0] txByte,
    output logic txValid,
    output logic irMode,
    // status to the rest of the uart
    output logic dataReadyFlag,
    output logic holdingEmptyFlag,
    output logic overrunError,
    output logic irq
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
    localparam logic [AW:0] ONE_C = (AW + 1)'(1);

    function automatic logic isAlias(input logic [31:0] a);
        return a >= usda_pkg::ALIAS_BASE &&
            a < usda_pkg::ALIAS_BASE + 32'(usda_pkg::ALIAS_SPAN) && a[1:0] == 2'h0;
    endfunction

    logic [usda_pkg::DATA_W-1:0] rxMem [DEPTH];
    logic [usda_pkg::DATA_W-1:0] txMem [DEPTH];
    logic [AW-1:0] rxRd, rxWr, txRd, txWr;
    logic [AW:0] rxCnt, txCnt;
    logic fifoEn;
    logic [usda_pkg::EV_WIDTH-1:0] evStat, evEn;
    logic access, rdAlias, wrAlias, rxPop, rxPush, rxFull, txPush, txPop, txFull;
    logic [7:0] rxHead;
    logic [usda_pkg::EV_WIDTH-1:0] evSet;

    // single-cycle access phase: pready is high only in the cycle after setup
    assign access = apbReq.psel && apbReq.penable;
    assign rdAlias = access && !apbReq.pwrite && isAlias(apbReq.paddr);
    assign wrAlias = access && apbReq.pwrite && isAlias(apbReq.paddr);
    // in non-fifo mode the depth collapses to one entry
    assign rxFull = fifoEn ? (rxCnt == DEPTH_C) : (rxCnt != '0);
    assign txFull = fifoEn ? (txCnt == DEPTH_C) : (txCnt != '0);
    assign rxPop = rdAlias && rxCnt != '0;
    assign rxPush = rxStrobe && (!rxFull || !fifoEn);
    assign txPop = txTake && txCnt != '0;
    // without fifos a write replaces the pending byte instead of being dropped
    assign txPush = wrAlias && (!txFull || !fifoEn);
    assign rxHead = rxMem[rxRd];
    assign evSet[usda_pkg::EV_OVERRUN] = rxStrobe && rxFull &&
        !(rdAlias && !fifoEn);
    assign evSet[usda_pkg::EV_RX_READY] = rxPush;
    assign evSet[usda_pkg::EV_TX_EMPTY] = txPop && txCnt == ONE_C && !txPush;

    // receive store
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rxRd <= '0;
            rxWr <= '0;
            rxCnt <= '0;
        end else if (!fifoEn) begin
            // one-deep buffer at slot 0: a new byte overwrites any unread one
            rxRd <= '0;
            rxWr <= '0;
            if (rxPush) begin
                rxCnt <= ONE_C;
            end else if (rxPop) begin
                rxCnt <= '0;
            end
        end else begin
            if (rxPush) begin
                rxWr <= AW'((rxWr + 1'b1) % DEPTH);
            end
            if (rxPop) begin
                rxRd <= AW'((rxRd + 1'b1) % DEPTH);
            end
            rxCnt <= rxCnt + (rxPush ? ONE_C : '0) - (rxPop ? ONE_C : '0);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rxPush) begin
            rxMem[fifoEn ? rxWr : '0] <= rxByte;
        end
    end

    // transmit store
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txRd <= '0;
            txWr <= '0;
            txCnt <= '0;
        end else if (!fifoEn) begin
            txRd <= '0;
            txWr <= '0;
            if (txPush) begin
                txCnt <= ONE_C;
            end else if (txPop) begin
                txCnt <= '0;
            end
        end else begin
            if (txPush) begin
                txWr <= AW'((txWr + 1'b1) % DEPTH);
            end
            if (txPop) begin
                txRd <= AW'((txRd + 1'b1) % DEPTH);
            end
            txCnt <= txCnt + (txPush ? ONE_C : '0) - (txPop ? ONE_C : '0);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (txPush) begin
            txMem[fifoEn ? txWr : '0] <= apbReq.pwdata[7:0];
        end
    end

    // transmitter view; a pop and a same-cycle replace both land, the write wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txByte <= '0;
            txValid <= 1'b0;
            holdingEmptyFlag <= 1'b1;
        end else begin
            txByte <= txMem[txRd];
            txValid <= txCnt != '0 && !txPop;
            holdingEmptyFlag <= (txCnt == '0 || (txPop && txCnt == ONE_C)) && !txPush;
        end
    end

    // control register and sticky events
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fifoEn <= 1'b0;
            irMode <= 1'b0;
            evEn <= '0;
        end else if (access && apbReq.pwrite) begin
            if (apbReq.paddr == usda_pkg::CTRL_ADDR) begin
                fifoEn <= apbReq.pwdata[usda_pkg::CTRL_FIFO_EN];
                irMode <= apbReq.pwdata[usda_pkg::CTRL_IR_MODE];
            end
            if (apbReq.paddr == usda_pkg::IRQ_EN_ADDR) begin
                evEn <= apbReq.pwdata[usda_pkg::EV_WIDTH-1:0];
            end
        end
    end

    // a set in the same cycle as a clear wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evStat <= '0;
        end else if (access && apbReq.pwrite && apbReq.paddr == usda_pkg::IRQ_CLR_ADDR) begin
            evStat <= (evStat & ~apbReq.pwdata[usda_pkg::EV_WIDTH-1:0]) | evSet;
        end else begin
            evStat <= evStat | evSet;
        end
    end

    // overrun in line status clears when the status word is read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            overrunError <= 1'b0;
        end else if (evSet[usda_pkg::EV_OVERRUN]) begin
            overrunError <= 1'b1;
        end else if (access && !apbReq.pwrite && apbReq.paddr == usda_pkg::STAT_ADDR) begin
            overrunError <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dataReadyFlag <= 1'b0;
            irq <= 1'b0;
        end else begin
            dataReadyFlag <= (rxCnt != '0 || rxPush) && !(rxPop && rxCnt == ONE_C && !rxPush);
            irq <= |((evStat | evSet) & evEn);
        end
    end

    // bus answer, registered from the setup cycle so it is ready in the access phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            apbRsp <= '0;
        end else begin
            apbRsp.pready <= apbReq.psel && !apbReq.penable;
            apbRsp.pslverr <= 1'b0;
            apbRsp.prdata <= '0;
            if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
                if (isAlias(apbReq.paddr)) begin
                    // stale byte is returned as zero when nothing is ready
                    apbRsp.prdata <= {24'h000000, (rxCnt != '0) ? rxHead : 8'h00};
                end else if (apbReq.paddr == usda_pkg::CTRL_ADDR) begin
                    apbRsp.prdata <= {30'h0, irMode, fifoEn};
                end else if (apbReq.paddr == usda_pkg::STAT_ADDR) begin
                    apbRsp.prdata[usda_pkg::STAT_DATA_READY] <= rxCnt != '0;
                    apbRsp.prdata[usda_pkg::STAT_OVERRUN] <= overrunError;
                    apbRsp.prdata[usda_pkg::STAT_HOLDING_EMPTY] <= txCnt == '0;
                end else if (apbReq.paddr == usda_pkg::IRQ_STAT_ADDR) begin
                    apbRsp.prdata <= 32'(evStat);
                end else if (apbReq.paddr == usda_pkg::IRQ_EN_ADDR) begin
                    apbRsp.prdata <= 32'(evEn);
                end else if (apbReq.paddr != usda_pkg::IRQ_CLR_ADDR) begin
                    apbRsp.pslverr <= 1'b1;
                end
            end else if (apbReq.psel && !apbReq.penable && !isAlias(apbReq.paddr) &&
                apbReq.paddr != usda_pkg::CTRL_ADDR && apbReq.paddr != usda_pkg::IRQ_CLR_ADDR &&
                apbReq.paddr != usda_pkg::IRQ_EN_ADDR) begin
                apbRsp.pslverr <= 1'b1;
            end
        end
    end
endmodule

// ===== sim/usda_checker.sv
`timescale 1ns/10ps
module usda_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // watched ports
    input wire usda_pkg::usda_apb_req_s apbReq,
    input wire usda_pkg::usda_apb_rsp_s apbRsp,
    input wire logic rxStrobe,
    input wire logic txTake,
    input wire logic txValid,
    input wire logic dataReadyFlag,
    input wire logic holdingEmptyFlag,
    input wire logic overrunError
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic isAlias;
    logic rdAcc;
    assign isAlias = (apbReq.paddr - usda_pkg::ALIAS_BASE) < 32'h40 && apbReq.paddr[1:0] == 2'h0;
    assign rdAcc = apbRsp.pready && !apbReq.pwrite;
    sequence setup_s; apbReq.psel && !apbReq.penable; endsequence
    sequence alias_wr_s; apbRsp.pready && apbReq.pwrite && isAlias; endsequence
    setup_ready_a: assert property (setup_s |=> apbRsp.pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("ready held too long");
    alias_ok_a: assert property (apbRsp.pready && isAlias |-> !apbRsp.pslverr)
        else $error("alias access errored");
    upper_zero_a: assert property (rdAcc && isAlias |-> apbRsp.prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    empty_clear_a: assert property (alias_wr_s |=> !holdingEmptyFlag)
        else $error("holding empty kept after write");
    rx_ready_a: assert property (rxStrobe && !(rdAcc && isAlias) |=> dataReadyFlag)
        else $error("data ready not raised");
    ovr_hold_a: assert property (overrunError && !(rdAcc &&
        apbReq.paddr == usda_pkg::STAT_ADDR) |=> overrunError)
        else $error("overrun dropped");
    ovr_cause_a: assert property ($rose(overrunError) |-> $past(rxStrobe))
        else $error("overrun without character");
    tx_hold_a: assert property (txValid && !txTake |=> txValid)
        else $error("transmit store lost");
endmodule

// ===== sim/usda_xcvr_model.sv
`timescale 1ns/10ps
module usda_xcvr_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // receive and transmit sides
    output logic rxStrobe,
    output logic [7:0] rxByte,
    output logic txTake,
    input wire logic [7:0] txByte,
    input wire logic txValid
);
    logic stall = 1'b0;
    logic [7:0] got[$];
    initial begin
        rxStrobe = 1'b0;
        rxByte = 8'h00;
        txTake = 1'b0;
    end
    task automatic send(input logic [7:0] b);
        @(posedge ref_clk);
        rxStrobe <= 1'b1;
        rxByte <= b;
        @(posedge ref_clk);
        rxStrobe <= 1'b0;
        rxByte <= ~b;
    endtask
    // every other cycle, so a valid that lags a pop is never counted twice
    always @(posedge ref_clk) begin
        if (txTake && txValid && !rst) begin
            got.push_back(txByte);
        end
        txTake <= !rst && !stall && !txTake && txValid;
    end
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    localparam int DEPTH = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    usda_pkg::usda_apb_req_s apbReq = '0;
    usda_pkg::usda_apb_rsp_s apbRsp;
    logic rxStrobe, txTake, txValid, irMode, dataReadyFlag, holdingEmptyFlag;
    logic overrunError, irq;
    logic [7:0] rxByte, txByte, b;
    logic [32:0] rd;
    logic [7:0] expQ[$];
    int failures = 0;
    int total_checks = 0;
    int seed = 53;
    int i;
    always #2 ref_clk = ~ref_clk;
    usda_shadow_alias #(.DEPTH(DEPTH)) usda_shadow_alias_inst (.ref_clk, .rst, .apbReq,
        .apbRsp, .rxStrobe, .rxByte, .txTake, .txByte, .txValid, .irMode, .dataReadyFlag,
        .holdingEmptyFlag, .overrunError, .irq);
    usda_xcvr_model usda_xcvr_model_inst (.ref_clk, .rst, .rxStrobe, .rxByte, .txTake,
        .txByte, .txValid);
    task automatic finish_test();
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 50);
        rd = {apbRsp.pslverr, apbRsp.prdata};
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (n == 50) begin
            failures++;
            finish_test();
        end
    endtask
    task automatic drain(input int k);
        int n = 0;
        while (usda_xcvr_model_inst.got.size() < k && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        repeat (4) @(posedge ref_clk);
        chk(usda_xcvr_model_inst.got.size(), k);
        while (expQ.size() > 0 && usda_xcvr_model_inst.got.size() > 0) begin
            chk(usda_xcvr_model_inst.got.pop_front(), expQ.pop_front());
        end
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        apb(0, usda_pkg::STAT_ADDR, 0);
        chk(rd, 33'h20);
        apb(0, 32'h50001184, 0);
        chk(rd[32], 1'b1);
        usda_xcvr_model_inst.send(8'h11);
        usda_xcvr_model_inst.send(8'h22);
        apb(0, usda_pkg::STAT_ADDR, 0);
        chk(rd, 33'h23);
        apb(0, usda_pkg::ALIAS_6, 0);
        chk(rd, 33'h22);
        apb(0, usda_pkg::ALIAS_7, 0);
        chk(rd, 33'h0);
        usda_xcvr_model_inst.stall <= 1'b1;
        apb(1, usda_pkg::ALIAS_7, 32'h1a5);
        apb(1, usda_pkg::ALIAS_8, 32'hffffffc3);
        chk(holdingEmptyFlag, 1'b0);
        expQ.push_back(8'hc3);
        usda_xcvr_model_inst.stall <= 1'b0;
        drain(1);
        apb(1, usda_pkg::CTRL_ADDR, 1);
        for (i = 0; i <= DEPTH; i++) begin
            b = 8'($random(seed));
            if (i < DEPTH) expQ.push_back(b);
            usda_xcvr_model_inst.send(b);
        end
        apb(0, usda_pkg::STAT_ADDR, 0);
        chk(rd, 33'h23);
        for (i = 0; i < DEPTH; i++) begin
            apb(0, usda_pkg::ALIAS_BASE + 32'(4 * i), 0);
            chk(rd, {25'h0, expQ.pop_front()});
        end
        usda_xcvr_model_inst.stall <= 1'b1;
        for (i = 0; i < DEPTH + 2; i++) begin
            b = 8'($random(seed));
            if (i < DEPTH) expQ.push_back(b);
            apb(1, usda_pkg::ALIAS_BASE + 32'(4 * (15 - i)), {24'hffffff, b});
        end
        usda_xcvr_model_inst.stall <= 1'b0;
        drain(DEPTH);
        apb(1, usda_pkg::CTRL_ADDR, 3);
        apb(1, usda_pkg::IRQ_CLR_ADDR, 7);
        apb(1, usda_pkg::IRQ_EN_ADDR, 2);
        chk(irMode, 1'b1);
        chk(irq, 1'b0);
        usda_xcvr_model_inst.send(8'h5a);
        apb(0, usda_pkg::IRQ_STAT_ADDR, 0);
        chk(rd[1], 1'b1);
        chk(irq, 1'b1);
        apb(1, usda_pkg::IRQ_EN_ADDR, 0);
        apb(0, usda_pkg::ALIAS_6, 0);
        chk(rd, 33'h5a);
        chk(irq, 1'b0);
        apb(1, usda_pkg::IRQ_CLR_ADDR, 7);
        apb(0, usda_pkg::IRQ_STAT_ADDR, 0);
        chk(rd, 33'h0);
        finish_test();
    end
endmodule
bind usda_shadow_alias usda_checker usda_checker_inst (.ref_clk, .rst, .apbReq, .apbRsp,
    .rxStrobe, .txTake, .txValid, .dataReadyFlag, .holdingEmptyFlag, .overrunError);
